// ---- design/lp_pkg.sv ----
// shared constants and types for the ten-port led pwm controller
package lp_pkg;

  localparam int NPORT = 10;

  // register addresses of the serial command map
  localparam logic [6:0] A_ALL  = 7'h0A;
  localparam logic [6:0] A_P03  = 7'h0B;
  localparam logic [6:0] A_P47  = 7'h0C;
  localparam logic [6:0] A_P89  = 7'h0D;
  localparam logic [6:0] A_IN70 = 7'h0E;
  localparam logic [6:0] A_IN98 = 7'h0F;
  localparam logic [6:0] A_CFG  = 7'h10;

  // mode_and_phase_control bit positions
  localparam int B_RUN   = 0;
  localparam int B_CSRUN = 1;
  localparam int B_RAMP  = 2;
  localparam int B_FADE  = 3;
  localparam int B_HOLD  = 4;
  localparam int B_STAG  = 5;
  localparam int B_OSC   = 7;

  // per-port output codes
  localparam logic [7:0] C_LOW    = 8'h00;
  localparam logic [7:0] C_INPUT  = 8'h01;
  localparam logic [7:0] C_SINK   = 8'h02;
  localparam logic [7:0] C_HIZ    = 8'hFF;
  localparam logic [7:0] PORT_RST = 8'hFF;

  // pwm timing: 256 counts per period, 32 counts per stagger step
  localparam logic [7:0] CNT_LAST   = 8'hFF;
  localparam int         PHASE_STEP = 32;

  // internal oscillator derived from the system clock
  localparam int          CLK_HZ  = 100_000_000;
  localparam int          OSC_HZ  = 32_000;
  localparam logic [11:0] OSC_DIV = 12'(CLK_HZ / OSC_HZ);

  // serial frame length and sequence lengths in pwm periods
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] CMD_BITS   = 5'h07;
  localparam logic [2:0] HOLD_PER   = 3'h2;
  localparam logic [2:0] FADE_PER   = 3'h2;
  localparam logic [2:0] RAMP_PER   = 3'h2;

  typedef struct packed {
    logic osc;
    logic stagger;
    logic cs_run;
  } lp_cfg_t;

  localparam lp_cfg_t CFG_RST = '0;

  typedef struct packed {
    logic       rd;
    logic [6:0] addr;
    logic [7:0] data;
  } lp_cmd_t;

  typedef enum logic [4:0] {
    ST_SHDN = 5'h01,
    ST_RUN  = 5'h02,
    ST_RAMP = 5'h04,
    ST_HOLD = 5'h08,
    ST_FADE = 5'h10
  } lp_state_t;

endpackage

// ---- design/lp_chan.sv ----
// one port output stage: static codes and phased pwm sink
`timescale 1ns/1ns
`default_nettype none
module lp_chan
  import lp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] code,
  input  wire logic [7:0] cnt,
  input  wire logic [7:0] phase,
  input  wire logic       active,
  output logic            sink_oe
);

  logic [7:0] rel;

  // position inside this port's own period, wraps modulo 256
  assign rel = cnt - phase;

  // low and input codes stay live in shutdown, sinks go high-z
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sink_oe <= 1'b0;
    end else begin
      case (code)
        C_LOW:   sink_oe <= 1'b1;
        C_INPUT: sink_oe <= 1'b0;
        C_SINK:  sink_oe <= active;
        C_HIZ:   sink_oe <= 1'b0;
        default: sink_oe <= active && (rel < code);
      endcase
    end
  end

  a_static_low : assert property (@(posedge clk) disable iff (!nrst)
    code == C_LOW |=> sink_oe) else $error("static low port not driven");
  a_input_hiz : assert property (@(posedge clk) disable iff (!nrst)
    code == C_INPUT ##1 code == C_INPUT |-> !sink_oe) else $error("input port driven");
  a_pwm_span : assert property (@(posedge clk) disable iff (!nrst)
    (active && code > C_SINK && code < C_HIZ && (cnt - phase) < code)
    |=> sink_oe) else $error("pwm sink off inside its interval");

endmodule
`default_nettype wire

// ---- design/lp_pwm_ctrl.sv ----
// ten-port pwm controller with serial registers, phasing and run/shutdown sequencing
// Behaviour
// - period is 256 pwm clocks, repeating
// - per-port duty 3 to 254 counts
// - stagger clear: all ports switch together
// - stagger set: successive ports shift 32 counts
// - bit7 selects pin: data out or clock
// - stop write with bit1 clear disarms wakeup
// - stop write with bit1 set arms wakeup
// - run, ramp bit clear: instant run
// - run, ramp bit set: ramp-up then run
// - run write aborts hold-off or fade-off
// - readback shows sequence status, stagger, wakeup
// - code 0x01 makes port a high-z input
// - input register returns pin levels
// - non-input ports read as zero
// - writes to input registers are ignored
// - frame: read flag, address, data
// - input bits map P7..P0, P9..P8
// - output codes: low, input, sink, duty, high-z
`timescale 1ns/1ns
`default_nettype none
module lp_pwm_ctrl
  import lp_pkg::*;
(
  input  wire logic             CLK,
  input  wire logic             NRST,
  input  wire logic             CS_N,
  input  wire logic             SCLK,
  input  wire logic             DIN,
  input  wire logic             DOUT_OSC_I,
  input  wire logic [NPORT-1:0] PORT_I,
  output logic                  DOUT_OSC_O,
  output logic                  DOUT_OSC_OE,
  output logic      [NPORT-1:0] PORT_O,
  output logic      [NPORT-1:0] PORT_OE
);

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!NRST);

  logic [2:0]             cs_q;
  logic [2:0]             sck_q;
  logic [1:0]             din_q;
  logic [2:0]             osc_q;
  logic [NPORT-1:0]       pin_q1;
  logic [NPORT-1:0]       pin_q2;
  logic                   sck_rise;
  logic                   sck_fall;
  logic                   cs_end;
  lp_cmd_t                sh_in_r;
  logic [4:0]             bit_r;
  logic [7:0]             sh_out_r;
  logic                   dout_r;
  logic                   dout_oe_r;
  logic                   wr_r;
  lp_cmd_t                wr_cmd_r;
  logic                   rd_req;
  logic [6:0]             rd_addr;
  logic [7:0]             rd_data;
  logic [NPORT-1:0][7:0]  port_r;
  logic [NPORT-1:0]       is_in;
  logic [NPORT-1:0]       in_view;
  logic [NPORT-1:0]       is_pwm;
  lp_cfg_t                cfg_r;
  lp_state_t              st_r;
  logic [2:0]             seq_r;
  logic                   cfg_wr;
  logic [7:0]             d;
  logic [11:0]            div_r;
  logic                   tick_r;
  logic [7:0]             cnt_r;
  logic                   run_cnt;
  logic                   period_end;
  logic                   active;
  logic [NPORT-1:0]       port_o_r;

  // pins from outside: two flops before any logic looks at them
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cs_q   <= 3'h7;
      sck_q  <= 3'h0;
      din_q  <= 2'h0;
      osc_q  <= 3'h0;
      pin_q1 <= '0;
      pin_q2 <= '0;
    end else begin
      cs_q   <= {cs_q[1:0], CS_N};
      sck_q  <= {sck_q[1:0], SCLK};
      din_q  <= {din_q[0], DIN};
      osc_q  <= {osc_q[1:0], DOUT_OSC_I};
      pin_q1 <= PORT_I;
      pin_q2 <= pin_q1;
    end
  end

  assign sck_rise = sck_q[1] & ~sck_q[2];
  assign sck_fall = ~sck_q[1] & sck_q[2];
  assign cs_end   = cs_q[1] & ~cs_q[2];

  // shift in the 16-bit command, msb first; extra bits are dropped
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sh_in_r <= '0;
      bit_r   <= 5'h00;
    end else if (cs_q[1]) begin
      bit_r <= 5'h00;
    end else if (sck_rise && bit_r != FRAME_BITS) begin
      sh_in_r <= lp_cmd_t'({sh_in_r[14:0], din_q[1]});
      bit_r   <= bit_r + 5'h01;
    end
  end

  // writes commit only on a full frame closed by chip select
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      wr_r     <= 1'b0;
      wr_cmd_r <= '0;
    end else begin
      wr_r     <= cs_end && bit_r == FRAME_BITS && !sh_in_r.rd;
      wr_cmd_r <= sh_in_r;
    end
  end

  // read address is known at the 8th rising edge; data follow at once
  assign rd_req  = sck_rise && !cs_q[1] && bit_r == CMD_BITS && sh_in_r[6];
  assign rd_addr = {sh_in_r[5:0], din_q[1]};

  assign is_in   = {is_in_gen(port_r)};
  assign in_view = pin_q2 & is_in;

  // read mux; group addresses read back their first port
  always_comb begin
    rd_data = 8'h00;
    case (rd_addr)
      A_ALL, A_P03: rd_data = port_r[0];
      A_P47:        rd_data = port_r[4];
      A_P89:        rd_data = port_r[8];
      A_IN70:       rd_data = in_view[7:0];
      A_IN98:       rd_data = {6'h00, in_view[9:8]};
      A_CFG: begin
        rd_data[B_OSC]   = cfg_r.osc;
        rd_data[B_STAG]  = cfg_r.stagger;
        rd_data[B_HOLD]  = st_r == ST_HOLD;
        rd_data[B_FADE]  = st_r == ST_FADE;
        rd_data[B_RAMP]  = st_r == ST_RAMP;
        rd_data[B_CSRUN] = cfg_r.cs_run;
        rd_data[B_RUN]   = st_r == ST_RUN || st_r == ST_RAMP;
      end
      default: begin
        if (rd_addr < A_ALL) begin
          rd_data = port_r[rd_addr[3:0]];
        end
      end
    endcase
  end

  // output shifter, changes on falling sclk so the host samples on rising
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sh_out_r <= 8'h00;
      dout_r   <= 1'b0;
    end else if (rd_req) begin
      sh_out_r <= rd_data;
    end else if (sck_fall && !cs_q[1]) begin
      dout_r   <= sh_out_r[7];
      sh_out_r <= {sh_out_r[6:0], 1'b0};
    end
  end

  // dual-use pin drives data only while it is not the clock input
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      dout_oe_r <= 1'b0;
    end else begin
      dout_oe_r <= !cfg_r.osc && !cs_q[1];
    end
  end

  // returns which ports are configured as logic inputs
  function automatic logic [NPORT-1:0] is_in_gen(input logic [NPORT-1:0][7:0] p);
    logic [NPORT-1:0] m;
    m = '0;
    for (int k = 0; k < NPORT; k++) begin
      m[k] = p[k] == C_INPUT;
    end
    return m;
  endfunction

  // true when a write address reaches port k, groups included
  function automatic logic port_hit(input logic [6:0] a, input int k);
    return a == 7'(k) || a == A_ALL || (a == A_P03 && k < 4)
        || (a == A_P47 && k >= 4 && k < 8) || (a == A_P89 && k >= 8);
  endfunction

  // port output registers; input-register addresses hit no port
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      port_r <= {NPORT{PORT_RST}};
    end else if (wr_r) begin
      for (int k = 0; k < NPORT; k++) begin
        if (port_hit(wr_cmd_r.addr, k)) begin
          port_r[k] <= wr_cmd_r.data;
        end
      end
    end
  end

  assign cfg_wr = wr_r && wr_cmd_r.addr == A_CFG;
  assign d      = wr_cmd_r.data;

  // wakeup arm is only taken from stop writes, run writes leave it alone
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cfg_r <= CFG_RST;
    end else if (cfg_wr) begin
      cfg_r.osc     <= d[B_OSC];
      cfg_r.stagger <= d[B_STAG];
      if (!d[B_RUN]) begin
        cfg_r.cs_run <= d[B_CSRUN];
      end
    end
  end

  // pwm clock: divided system clock or edges of the external pin
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      div_r  <= 12'h000;
      tick_r <= 1'b0;
    end else begin
      if (cfg_r.osc || div_r == OSC_DIV - 12'h001) begin
        div_r <= 12'h000;
      end else begin
        div_r <= div_r + 12'h001;
      end
      // external clock above 100kHz is the host's fault, sampling still copes
      tick_r <= cfg_r.osc ? (osc_q[1] & ~osc_q[2])
                          : (div_r == OSC_DIV - 12'h001);
    end
  end

  always_comb begin
    for (int k = 0; k < NPORT; k++) begin
      is_pwm[k] = port_r[k] > C_SINK && port_r[k] < C_HIZ;
    end
  end

  // counter idles at zero when no port and no sequence needs it
  assign run_cnt    = |is_pwm || st_r == ST_HOLD || st_r == ST_FADE || st_r == ST_RAMP;
  assign period_end = tick_r && cnt_r == CNT_LAST;
  assign active     = st_r != ST_SHDN;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_r <= 8'h00;
    end else if (!run_cnt) begin
      cnt_r <= 8'h00;
    end else if (tick_r) begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // run/shutdown sequencer, sequence lengths counted in whole periods
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_r  <= ST_SHDN;
      seq_r <= 3'h0;
    end else begin
      if (period_end) begin
        seq_r <= seq_r + 3'h1;
      end
      case (st_r)
        ST_SHDN: begin
          seq_r <= 3'h0;
          if (cfg_wr && d[B_RUN]) begin
            st_r <= d[B_RAMP] ? ST_RAMP : ST_RUN;
          end
        end
        ST_RUN: begin
          seq_r <= 3'h0;
          if (cfg_wr && !d[B_RUN]) begin
            st_r <= ST_HOLD;
          end
        end
        ST_RAMP: begin
          if (cfg_wr && !d[B_RUN]) begin
            st_r  <= ST_HOLD;
            seq_r <= 3'h0;
          end else if (period_end && seq_r == RAMP_PER - 3'h1) begin
            st_r <= ST_RUN;
          end
        end
        ST_HOLD: begin
          if (cfg_wr && d[B_RUN]) begin
            st_r <= ST_RUN;
          end else if (period_end && seq_r == HOLD_PER - 3'h1) begin
            st_r  <= ST_FADE;
            seq_r <= 3'h0;
          end
        end
        ST_FADE: begin
          if (cfg_wr && d[B_RUN]) begin
            st_r <= ST_RUN;
          end else if (period_end && seq_r == FADE_PER - 3'h1) begin
            st_r <= ST_SHDN;
          end
        end
        default: st_r <= ST_SHDN;
      endcase
    end
  end

  // one output stage per port; stagger repeats every eight ports
  for (genvar k = 0; k < NPORT; k++) begin : g_port
    localparam logic [7:0] PH = 8'((k % 8) * PHASE_STEP);
    lp_chan u_chan (
      .clk     (CLK),
      .nrst    (NRST),
      .code    (port_r[k]),
      .cnt     (cnt_r),
      .phase   (cfg_r.stagger ? PH : 8'h00),
      .active  (active),
      .sink_oe (PORT_OE[k])
    );
  end

  // open-drain pads: the level driven is always low
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      port_o_r <= '0;
    end else begin
      port_o_r <= '0;
    end
  end

  assign PORT_O      = port_o_r;
  assign DOUT_OSC_O  = dout_r;
  assign DOUT_OSC_OE = dout_oe_r;

  a_pwm_wrap : assert property (period_end && run_cnt |=> cnt_r == 8'h00)
    else $error("pwm counter did not wrap after 256 counts");
  a_cnt_hold : assert property (!tick_r && run_cnt ##1 run_cnt |-> $stable(cnt_r))
    else $error("pwm counter moved without a tick");
  a_in_mask : assert property (rd_req && rd_addr == A_IN70
    |=> (sh_out_r & ~$past(is_in[7:0])) == 8'h00)
    else $error("non-input port read as one");
  a_in_ro : assert property (wr_r && (wr_cmd_r.addr == A_IN70 || wr_cmd_r.addr == A_IN98)
    |=> $stable(port_r) && $stable(cfg_r) && ($stable(st_r) || $past(period_end)))
    else $error("write to input register changed state");
  a_run_now : assert property (st_r == ST_SHDN && cfg_wr && d[B_RUN] && !d[B_RAMP]
    |=> st_r == ST_RUN) else $error("instant run not taken");
  a_ramp_go : assert property (st_r == ST_SHDN && cfg_wr && d[B_RUN] && d[B_RAMP]
    |=> st_r == ST_RAMP) else $error("ramp-up not entered");
  a_seq_abort : assert property ((st_r == ST_HOLD || st_r == ST_FADE) && cfg_wr && d[B_RUN]
    |=> st_r == ST_RUN) else $error("shutdown sequence not aborted");
  a_stop_arm : assert property (cfg_wr && !d[B_RUN]
    |=> cfg_r.cs_run == $past(d[B_CSRUN]) && st_r != ST_RUN && st_r != ST_RAMP)
    else $error("stop write mishandled");
  a_cfg_status : assert property (rd_req && rd_addr == A_CFG
    |=> sh_out_r[B_RUN] == $past(st_r == ST_RUN || st_r == ST_RAMP)
        && sh_out_r[B_HOLD] == $past(st_r == ST_HOLD))
    else $error("status readback wrong");

endmodule
`default_nettype wire

// ---- sim/lp_host.sv ----
// host model: drives chip-select, serial clock and data, and samples the data pin
`timescale 1ns/1ns
`default_nettype none
module lp_host
  import lp_pkg::*;
(
  input  wire logic clk,
  input  wire logic dout,
  output logic      cs_n,
  output logic      sclk,
  output logic      din
);
  // idle: deselected, clock parked low
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end

  // one 16-bit frame, msb first; sclk runs only inside the frame, 60 ns high and 70 ns low
  task automatic xfer(input lp_cmd_t cmd, output logic [7:0] rdata);
    logic [15:0] w;
    w = cmd;
    rdata = 8'h00;
    @(posedge clk);
    cs_n <= 1'b0;
    din  <= w[15];
    repeat (7) @(posedge clk);
    for (int i = 15; i >= 0; i--) begin
      // read data is taken at the rising edge, before the clock moves
      if (i < 8) rdata[i] = dout;
      sclk <= 1'b1;
      repeat (6) @(posedge clk);
      sclk <= 1'b0;
      // a released data line shows the inverse, never the stale bit
      din  <= (i > 0) ? w[i-1] : ~w[0];
      repeat (7) @(posedge clk);
    end
    cs_n <= 1'b1;
    // gap covers commit latency and the 4-clock frame spacing
    repeat (12) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ---- sim/lp_pwm_ctrl_test.sv ----
// self-checking bench: register access, input readback, mode sequencing and pwm phasing
`timescale 1ns/1ns
`default_nettype none
module lp_pwm_ctrl_test
  import lp_pkg::*;
;
  logic             clk;
  logic             nrst;
  logic             ext_osc;
  logic       [2:0] osc_div = 3'h0;
  logic [NPORT-1:0] pin_lvl;
  logic             dout_o;
  logic             dout_oe;
  logic [NPORT-1:0] port_o;
  logic [NPORT-1:0] port_oe;
  wire logic        cs_n;
  wire logic        sclk;
  wire logic        din;
  wire logic        osc_pin = dout_oe ? dout_o : ext_osc;
  wire [NPORT-1:0]  port_i = pin_lvl & ~port_oe;
  int               failures;
  int               samples_checked;
  int               oe_cnt = 0;
  int               n;
  int               on_cnt [NPORT];
  int               rise_at [NPORT];

  localparam logic [7:0] WALK_W [13] = '{8'h02, 8'h00, 8'h01, 8'h00, 8'h01, 8'h02, 8'h80,
                                         8'h00, 8'h01, 8'h80, 8'h20, 8'h25, 8'hA0};
  localparam logic [7:0] WALK_E [13] = '{8'h02, 8'h00, 8'h01, 8'h10, 8'h01, 8'h12, 8'h00,
                                         8'h08, 8'h01, 8'h00, 8'h20, 8'h25, 8'h00};
  localparam int         WALK_T [13] = '{0, 0, 0, 0, 0, 0, 4400, 0, 0, 9500, 0, 0, 9500};
  localparam int         ON_64 [NPORT] = '{default: 512};
  localparam int         ON_MIX [NPORT] = '{24, 24, 24, 24, 2032, 2032, 2032, 2032, 1024, 1024};

  lp_pwm_ctrl lp_pwm_ctrl_inst (
    .CLK         (clk),
    .NRST        (nrst),
    .CS_N        (cs_n),
    .SCLK        (sclk),
    .DIN         (din),
    .DOUT_OSC_I  (osc_pin),
    .PORT_I      (port_i),
    .DOUT_OSC_O  (dout_o),
    .DOUT_OSC_OE (dout_oe),
    .PORT_O      (port_o),
    .PORT_OE     (port_oe)
  );

  lp_host lp_host_inst (
    .clk  (clk),
    .dout (osc_pin),
    .cs_n (cs_n),
    .sclk (sclk),
    .din  (din)
  );

  // 100 MHz system clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // pwm clock on the dual-use pin; 8 clk period, far above a board clock, keeps the run short
  always @(posedge clk) begin
    osc_div <= osc_div + 3'h1;
    ext_osc <= osc_div[2];
  end

  // counts cycles in which the block drives the dual-use pin
  always @(posedge clk) begin
    if (dout_oe === 1'b1) oe_cnt <= oe_cnt + 1;
  end

  task automatic conclude();
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    lp_host_inst.xfer(lp_cmd_t'{1'b0, a, d}, r);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input string what);
    logic [7:0] r;
    lp_host_inst.xfer(lp_cmd_t'{1'b1, a, 8'h00}, r);
    check(what, 32'(exp), 32'(r));
  endtask

  // one full period after settling: on-time and first rise of every port
  task automatic measure(input int exp_on [NPORT], input int step);
    logic [NPORT-1:0] prev;
    repeat (2100) @(posedge clk);
    prev = port_oe;
    for (int k = 0; k < NPORT; k++) begin
      on_cnt[k] = 0;
      rise_at[k] = -1;
    end
    for (int t = 0; t < 2048; t++) begin
      @(posedge clk);
      for (int k = 0; k < NPORT; k++) begin
        if (port_oe[k] === 1'b1) on_cnt[k]++;
        if (port_oe[k] === 1'b1 && prev[k] === 1'b0 && rise_at[k] < 0) rise_at[k] = t;
      end
      prev = port_oe;
    end
    for (int k = 0; k < NPORT; k++) begin
      check($sformatf("port%0d_on_cycles", k), 32'(exp_on[k]), 32'(on_cnt[k]));
      check($sformatf("port%0d_phase", k), 32'((k % 8) * step),
            32'((rise_at[k] - rise_at[0] + 2048) % 2048));
    end
  endtask

  // watchdog well past the expected run of about 60k cycles
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    conclude();
  end

  // main sequence
  initial begin
    failures = 0;
    samples_checked = 0;
    ext_osc = 1'b0;
    nrst = 1'b0;
    pin_lvl = 10'h2A5;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd_chk(A_CFG, 8'h00, "mode_and_phase_control");
    rd_chk(7'h00, PORT_RST, "port0_code");
    n = oe_cnt;
    wr(7'h20, 8'h5A);
    check("dout_driven", 32'h1, 32'(oe_cnt > n));
    wr(A_ALL, C_LOW);
    check("port_sink", 32'h3FF, 32'(port_oe));
    check("port_level", 32'h0, 32'(port_o));
    wr(A_ALL, C_SINK);
    check("port_sink", 32'h0, 32'(port_oe));
    wr(A_ALL, C_INPUT);
    check("port_sink", 32'h0, 32'(port_oe));
    rd_chk(A_IN70, 8'hA5, "inputs_low");
    rd_chk(A_IN98, 8'h02, "inputs_high");
    wr(A_P47, C_HIZ);
    wr(A_P89, C_SINK);
    rd_chk(A_IN70, 8'h05, "inputs_low");
    rd_chk(A_IN98, 8'h00, "inputs_high");
    wr(A_IN70, 8'h00);
    rd_chk(7'h00, C_INPUT, "port0_code");
    rd_chk(7'h04, C_HIZ, "port4_code");
    rd_chk(A_IN70, 8'h05, "inputs_low");
    // mode walk; stagger only touched in shutdown, reads only while the pin is data out
    for (int i = 0; i < 13; i++) begin
      wr(A_CFG, WALK_W[i]);
      repeat (WALK_T[i]) @(posedge clk);
      if (WALK_W[i][7] == 1'b0) rd_chk(A_CFG, WALK_E[i], "mode_and_phase_control");
    end
    wr(A_ALL, 8'h40);
    check("port_sink", 32'h0, 32'(port_oe));
    wr(A_CFG, 8'hA1);
    measure(ON_64, 256);
    wr(A_P03, 8'h03);
    wr(A_P47, 8'hFE);
    wr(A_P89, 8'h80);
    measure(ON_MIX, 256);
    wr(A_ALL, 8'h40);
    wr(A_CFG, 8'h80);
    repeat (9500) @(posedge clk);
    wr(A_CFG, 8'h81);
    measure(ON_64, 0);
    n = oe_cnt;
    wr(7'h20, 8'h5A);
    check("dout_driven", 32'h0, 32'(oe_cnt > n));
    conclude();
  end
endmodule
`default_nettype wire
